// ### core/pcrc_top.sv
// Summary of operation
// - Taps from mask bits 15..1, separate length
// - Length field holds polynomial length minus one
// - x^0 always applied; x^16 implied at 16
// - FIFO depth 8 if length over 8, else 16
// - Byte writes allowed; data written before shifting
// - Count increments when word MSb byte written
// - Shift only when started and count nonzero
// - Count decrements per word; run until zero
// - One bit per clock, length times words
// - Full at depth, empty at zero count
// - Write while full wraps count, no interrupt
// - Interrupt when count goes one to zero
// - Start enables; clear stops after FIFO empty
// - Sleep freezes state, resumes afterwards
// - Idle-stop set: idle acts as sleep
// - Status: count 12-8, full 7, empty 6
`timescale 1ns/1ps
module pcrc_top
  import pcrc_pkg::*;
#(
  parameter int unsigned FIFO_MAX = 16
)(
  input  wire logic                       clk,        // 40 MHz clock
  input  wire logic                       rst,        // Async reset, high
  input  wire logic                       psel,       // APB select
  input  wire logic                       penable,    // APB enable
  input  wire logic                       pwrite,     // APB direction
  input  wire logic [pcrc_pkg::ADDR_W-1:0] paddr,     // APB address
  input  wire logic [pcrc_pkg::DATA_W-1:0] pwdata,    // APB write data
  input  wire logic [3:0]                 pstrb,      // APB byte strobes
  output logic      [pcrc_pkg::DATA_W-1:0] prdata,    // APB read data
  output logic                            pready,     // APB ready
  output logic                            pslverr,    // APB error
  input  wire logic                       sleep_mode, // Device asleep
  input  wire logic                       idle_mode,  // Device idle
  output logic                            crc_irq     // Count 1->0 pulse
);
  import pcrc_pkg::*;

  pcrc_ctrl_t    ctrl;
  pcrc_apb_req_t req;
  logic [15:1]   taps;
  logic [15:0]   crc;
  logic [15:0]   stage;
  logic [15:0]   fifo_mem [FIFO_MAX];
  logic [3:0]    wr_ptr;
  logic [3:0]    rd_ptr;
  logic [4:0]    count;
  logic [3:0]    bit_idx;
  logic          running;

  // Request carrier
  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign req.strb  = pstrb;

  // Bus decode
  wire hit_ctrl   = (req.addr == ADDR_CTRL);
  wire hit_taps   = (req.addr == ADDR_TAPS);
  wire hit_data   = (req.addr == ADDR_DATA);
  wire hit_result = (req.addr == ADDR_RESULT);
  wire hit_any    = hit_ctrl | hit_taps | hit_data | hit_result;
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable & pready;
  wire wr_acc     = access_ph & req.write & hit_any;

  // Depth and fill state
  wire        long_poly = (ctrl.poly_length_field > POLY_LENGTH_FIELD_DEEP_MAX);
  wire [4:0]  depth     = long_poly ? DEPTH_LONG : DEPTH_SHORT;
  wire [3:0]  last_slot = 4'(depth - 5'h01);
  wire        is_full   = (count == depth);
  wire        is_empty  = (count == COUNT_RST);

  // Data port: a word completes when the lane holding its MSb is written
  wire        msb_lane  = long_poly;
  wire        lane0_wr  = wr_acc & hit_data & req.strb[0];
  wire        lane1_wr  = wr_acc & hit_data & req.strb[1];
  wire [15:0] merged    = {lane1_wr ? req.wdata[15:8] : stage[15:8],
                           lane0_wr ? req.wdata[7:0]  : stage[7:0]};
  wire        push      = msb_lane ? lane1_wr : lane0_wr;
  wire        wrap      = push & is_full;

  // Power save: freezes the engine, bus stays live
  wire        hold      = sleep_mode | (idle_mode & ctrl.idle_stop);

  // Shifter
  wire        shift_en  = running & ~is_empty & ~hold;
  wire [15:0] head      = fifo_mem[rd_ptr];
  wire        data_bit  = head[bit_idx];
  wire        word_end  = shift_en & (bit_idx == 4'h0);
  wire        pop       = word_end & ~wrap;
  wire        do_push   = push & ~wrap;

  // CRC engine: length-masked LFSR
  wire [15:0] len_mask  = 16'((17'h0_0002 << ctrl.poly_length_field) - 17'h0_0001);
  wire [15:0] poly      = {taps[15:1], 1'b1};
  wire        fb        = crc[ctrl.poly_length_field] ^ data_bit;
  wire [15:0] crc_shl   = {crc[14:0], 1'b0};
  wire [15:0] next_crc  = (crc_shl ^ (fb ? poly : 16'h0000)) & len_mask;

  wire [4:0]  next_count =
    wrap              ? COUNT_RST :
    (do_push & ~pop)  ? 5'(count + 5'h01) :
    (pop & ~do_push)  ? 5'(count - 5'h01) :
                        count;

  // Count may drop from one only through a pop, never through a wrap
  wire        next_irq  = pop & ~do_push & (count == 5'h01);

  // Run latch: a cleared start bit still lets the FIFO drain
  wire        next_running = ctrl.go | (running & ~is_empty);

  // Read mux
  wire [31:0] ctrl_rd;
  assign ctrl_rd = {18'h0_0000, ctrl.idle_stop, count, is_full, is_empty,
                    1'b0, ctrl.go, ctrl.poly_length_field};
  wire [31:0] rd_val =
    hit_ctrl                ? ctrl_rd :
    hit_taps                ? {16'h0000, taps, 1'b0} :
    (hit_data | hit_result) ? {16'h0000, crc} :
                              32'h0000_0000;

  // APB answer: one access cycle, prepared in setup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      prdata  <= (setup_ph & ~req.write) ? rd_val : 32'h0000_0000;
    end
  end

  // Control register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl.idle_stop <= 1'b0;
      ctrl.go        <= 1'b0;
      ctrl.poly_length_field      <= POLY_LENGTH_FIELD_RST;
    end
    else if (wr_acc & hit_ctrl)
    begin
      if (req.strb[1])
        ctrl.idle_stop <= req.wdata[CTRL_IDLE_STOP];
      if (req.strb[0])
      begin
        ctrl.go   <= req.wdata[CTRL_GO];
        ctrl.poly_length_field <= req.wdata[CTRL_POLY_LENGTH_FIELD_HI:0];
      end
    end
  end

  // Tap mask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      taps <= TAPS_RST[15:1];
    else if (wr_acc & hit_taps)
    begin
      if (req.strb[0])
        taps[7:1] <= req.wdata[7:1];
      if (req.strb[1])
        taps[15:8] <= req.wdata[15:8];
    end
  end

  // Staging for byte-wise word assembly
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stage <= 16'h0000;
    else if (lane0_wr | lane1_wr)
      stage <= merged;
  end

  // FIFO storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (do_push)
      fifo_mem[wr_ptr] <= merged & len_mask;
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= COUNT_RST;
    end
    else
    begin
      count <= next_count;
      if (wrap)
      begin
        wr_ptr <= 4'h0;
        rd_ptr <= 4'h0;
      end
      else
      begin
        if (do_push)
          wr_ptr <= (wr_ptr >= last_slot) ? 4'h0 : 4'(wr_ptr + 4'h1);
        if (pop)
          rd_ptr <= (rd_ptr >= last_slot) ? 4'h0 : 4'(rd_ptr + 4'h1);
      end
    end
  end

  // Bit index walks poly_length_field..0 per word; tracks poly_length_field when stopped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bit_idx <= POLY_LENGTH_FIELD_RST;
    else if (wrap | ~shift_en & ~hold | word_end)
      bit_idx <= ctrl.poly_length_field;
    else if (shift_en)
      bit_idx <= 4'(bit_idx - 4'h1);
  end

  // Run state freezes while held
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      running <= 1'b0;
    else if (~hold)
      running <= next_running;
  end

  // CRC result; software may seed it through the result offset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc <= CRC_RST;
    else if (wr_acc & hit_result)
      crc <= req.wdata[15:0] & len_mask;
    else if (shift_en)
      crc <= next_crc;
  end

  // Interrupt pulse is held off by power save, since a pop needs shift_en
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc_irq <= 1'b0;
    else
      crc_irq <= next_irq;
  end

endmodule

// ### common/pcrc_pkg.sv
package pcrc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses on the APB
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_TAPS   = 12'h004;
  localparam logic [11:0] ADDR_DATA   = 12'h008;
  localparam logic [11:0] ADDR_RESULT = 12'h00C;

  // Control/status field positions
  localparam int unsigned CTRL_IDLE_STOP = 13;
  localparam int unsigned CTRL_VALID_WORD_COUNT_LO  = 8;
  localparam int unsigned CTRL_VALID_WORD_COUNT_HI  = 12;
  localparam int unsigned CTRL_FULL      = 7;
  localparam int unsigned CTRL_EMPTY     = 6;
  localparam int unsigned CTRL_GO        = 4;
  localparam int unsigned CTRL_POLY_LENGTH_FIELD_HI   = 3;

  // Depth selection
  localparam logic [3:0] POLY_LENGTH_FIELD_DEEP_MAX = 4'h7;
  localparam logic [4:0] DEPTH_SHORT   = 5'h10;
  localparam logic [4:0] DEPTH_LONG    = 5'h08;

  // Reset values
  localparam logic [3:0]  POLY_LENGTH_FIELD_RST  = 4'h0;
  localparam logic [15:0] TAPS_RST  = 16'h0000;
  localparam logic [15:0] CRC_RST   = 16'h0000;
  localparam logic [4:0]  COUNT_RST = 5'h00;

  typedef struct packed {
    logic       idle_stop;
    logic       go;
    logic [3:0] poly_length_field;
  } pcrc_ctrl_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } pcrc_apb_req_t;

endpackage

// ### tb/pcrc_assertions.sv
`timescale 1ns/1ps
module pcrc_assertions
  import pcrc_pkg::*;
(
  input wire logic        clk,        // Clock
  input wire logic        rst,        // Reset
  input wire logic        psel,       // Select
  input wire logic        penable,    // Enable
  input wire logic        pwrite,     // Direction
  input wire logic [11:0] paddr,      // Address
  input wire logic [31:0] pwdata,     // Write data
  input wire logic [3:0]  pstrb,      // Strobes
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic        sleep_mode, // Sleep
  input wire logic        idle_mode,  // Idle
  input wire logic        crc_irq     // Interrupt
);
  logic rd_ok;
  logic rd_ctrl;
  logic rd_taps;
  assign rd_ok   = psel && penable && pready && !pwrite && !pslverr;
  assign rd_ctrl = rd_ok && paddr == ADDR_CTRL;
  assign rd_taps = rd_ok && paddr == ADDR_TAPS;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_irq_single: assert property (crc_irq |=> !crc_irq)
    else $error("irq longer than one cycle");
  chk_sleep_quiet: assert property (sleep_mode [*3] |-> !crc_irq)
    else $error("irq while asleep");
  chk_empty_flag: assert property (rd_ctrl |-> prdata[6] == (prdata[12:8] == 5'h00))
    else $error("empty flag disagrees with count");
  chk_full_depth: assert property (rd_ctrl && prdata[7] |->
    prdata[12:8] == (prdata[3:0] > 4'h7 ? 5'h08 : 5'h10)) else $error("full at wrong count");
  chk_count_max: assert property (rd_ctrl |->
    prdata[12:8] <= (prdata[3:0] > 4'h7 ? 5'h08 : 5'h10)) else $error("count above depth");
  chk_ctrl_unused: assert property (rd_ctrl |-> prdata[31:14] == '0 && !prdata[5])
    else $error("unused control bits set");
  chk_taps_bit0: assert property (rd_taps |-> !prdata[0])
    else $error("taps bit 0 not zero");
  chk_ready_after: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_unmapped_err: assert property (psel && !penable && paddr[11:4] != 8'h00 |=>
    pslverr && prdata == '0) else $error("unmapped access not refused");
  cover property (crc_irq);
  cover property (rd_ctrl && prdata[7]);
  cover property (pslverr);
endmodule
bind pcrc_top pcrc_assertions chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
  .crc_irq(crc_irq));

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import pcrc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleep_mode = 1'b0, idle_mode = 1'b0, pready, pslverr, crc_irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [3:0]  pstrb = 4'h0;
  int n_fail = 0, n_compared = 0, n_irq = 0, cyc = 0, irq_cyc = 0, t_eff = 0;
  pcrc_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .idle_mode(idle_mode), .crc_irq(crc_irq));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (crc_irq === 1'b1)
    begin
      n_irq <= n_irq + 1;
      irq_cyc <= cyc;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer, then one idle cycle before the next setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rdat = prdata; err = pslverr; t_eff = cyc;
    check(32'(n < 20), 32'h0000_0001);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] ref_crc(logic [15:0] c, logic [15:0] d, int p, logic [15:0] t);
    logic fb;
    for (int i = p; i >= 0; i--)
    begin
      fb = c[p] ^ d[i];
      c = ((c << 1) ^ (fb ? (t | 16'h0001) : 16'h0000)) & 16'((1 << (p + 1)) - 1);
    end
    return c;
  endfunction
  task automatic t_reset;
    apb(0, ADDR_CTRL, 0, 0); check(rdat, 32'h0000_0040);
    apb(1, ADDR_TAPS, 32'hFFFF_FFFF, 4'hF); apb(0, ADDR_TAPS, 0, 0);
    check(rdat, 32'h0000_FFFE);
    apb(1, ADDR_CTRL, 32'h0000_200F, 4'hF); apb(0, ADDR_CTRL, 0, 0);
    check(rdat, 32'h0000_204F);
    apb(0, 12'h010, 0, 0);
    check(32'(err), 32'h0000_0001);
    check(rdat, 32'h0000_0000);
    apb(1, ADDR_CTRL, 0, 4'hF);
    $display("test reset done");
  endtask
  task automatic t_full(input int p, input int depth);
    int k;
    apb(1, ADDR_CTRL, 32'(p), 4'hF);
    if (p > 7)
    begin
      apb(1, ADDR_DATA, 32'h0000_00FF, 4'h1); apb(0, ADDR_CTRL, 0, 0);
      check(32'(rdat[12:8]), 32'h0000_0000);
    end
    for (int i = 0; i < depth; i++) apb(1, ADDR_DATA, 32'(i), 4'h3);
    apb(0, ADDR_CTRL, 0, 0); check(rdat, 32'((depth << 8) | 'h80 | p));
    k = n_irq;
    apb(1, ADDR_DATA, 32'h0000_0011, 4'h3); apb(0, ADDR_CTRL, 0, 0);
    check(rdat, 32'('h40 | p));
    check(32'(n_irq - k), 32'h0000_0000);
    $display("test full depth %0d done", depth);
  endtask
  task automatic t_crc(input int p, input logic [15:0] t, input int n);
    logic [15:0] c, d;
    int k, t0, m, q;
    c = 16'h0000; m = 0;
    apb(1, ADDR_TAPS, {16'h0000, t}, 4'hF); apb(1, ADDR_CTRL, 32'(p), 4'hF);
    apb(1, ADDR_RESULT, 0, 4'hF);
    for (int i = 0; i < n; i++)
    begin
      d = 16'hA5C3 ^ 16'(i * 'h1357);
      apb(1, ADDR_DATA, {16'h0000, d}, p > 7 ? 4'h3 : 4'h1);
      c = ref_crc(c, d, p, t);
    end
    apb(0, ADDR_CTRL, 0, 0); check(32'(rdat[12:8]), 32'(n));
    q = n_irq;
    apb(1, ADDR_CTRL, 32'(p) | 32'h10, 4'hF);
    t0 = t_eff;
    do
    begin
      apb(0, ADDR_CTRL, 0, 0);
      m++;
    end while (rdat[6] !== 1'b1 && m < 100);
    k = irq_cyc - t0 - (p + 1) * n;
    check(32'(k >= 1 && k <= 2), 32'h0000_0001);
    check(32'(n_irq - q), 32'h0000_0001);
    apb(0, ADDR_DATA, 0, 0); check(rdat, {16'h0000, c});
    apb(1, ADDR_CTRL, 0, 4'hF);
    $display("test crc length %0d done", p + 1);
  endtask
  task automatic t_hold;
    sleep_mode <= 1'b1;
    apb(1, ADDR_CTRL, 32'h0000_001F, 4'hF); apb(1, ADDR_DATA, 32'h0000_1234, 4'h3);
    repeat (40) @(posedge clk);
    apb(0, ADDR_CTRL, 0, 0); check(rdat, 32'h0000_011F);
    sleep_mode <= 1'b0; idle_mode <= 1'b1;
    apb(1, ADDR_CTRL, 32'h0000_201F, 4'hF);
    repeat (40) @(posedge clk);
    apb(0, ADDR_CTRL, 0, 0); check(rdat, 32'h0000_211F);
    apb(1, ADDR_CTRL, 32'h0000_001F, 4'hF);
    repeat (40) @(posedge clk);
    apb(0, ADDR_CTRL, 0, 0); check(rdat, 32'h0000_005F);
    idle_mode <= 1'b0;
    apb(1, ADDR_CTRL, 0, 4'hF);
    $display("test hold done");
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_full(7, 16);
    t_full(8, 8);
    t_crc(15, 16'h1020, 3);
    t_crc(4, 16'h0004, 2);
    t_crc(7, 16'h0006, 4);
    t_hold;
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report;
  end
endmodule
